// [dv/mlb_buffer_assertions.sv]
// Port checker for the link buffer
`timescale 1ns/100ps
module mlb_buffer_chk
  import mlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic init_req,
  input wire logic send_req,
  input wire logic recv_req,
  input wire logic [MLB_CPU_W-1:0] src_cpu,
  input wire logic [MLB_CPU_W-1:0] dst_cpu,
  input wire logic [MLB_LEN_W-1:0] send_len,
  input wire logic send_data_take,
  input wire logic recv_data_valid,
  input wire logic [MLB_LEN_W-1:0] recv_len,
  input wire logic [MLB_CNT_W-1:0] tx_cap,
  input wire logic [MLB_CNT_W-1:0] rx_cap,
  input wire logic busy,
  input wire logic done,
  input wire logic refused,
  input wire logic initialized
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [6:0] tk_q;
  logic [6:0] vl_q;
  logic ini_q;
  wire idle = !busy && !done;
  wire [6:0] sum = 7'(tx_cap) + 7'(rx_cap);
  // Words moved since the last done
  always_ff @(posedge ref_clk) begin
    if (sys_rst || done) begin
      tk_q <= 7'h00;
      vl_q <= 7'h00;
    end else begin
      tk_q <= tk_q + 7'(send_data_take);
      vl_q <= vl_q + 7'(recv_data_valid);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || done) begin
      ini_q <= 1'b0;
    end else if (init_req && idle) begin
      ini_q <= 1'b1;
    end
  end
  done_pulse_a: assert property (done |=> !done)
    else $error("done held too long");
  refuse_flag_a: assert property (refused |-> done)
    else $error("refused without done");
  busy_end_a: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  valid_busy_a: assert property (recv_data_valid |-> busy)
    else $error("word outside an operation");
  take_count_a: assert property (
    done && !refused && tk_q != 0 |-> tk_q == 7'(send_len))
    else $error("taken words differ from length");
  word_count_a: assert property (
    done && !refused && vl_q != 0 |-> vl_q == 7'(recv_len))
    else $error("delivered words differ from length");
  tx_full_a: assert property (send_req && idle && !init_req &&
    !$past(sys_rst) && tx_cap == 0 && $stable(src_cpu) &&
    $stable(dst_cpu) |=> refused)
    else $error("send accepted with no free field");
  rx_empty_a: assert property (recv_req && !send_req &&
    idle && !init_req && !$past(sys_rst) && rx_cap == 0 &&
    $stable(src_cpu) && $stable(dst_cpu) |=> refused)
    else $error("receive accepted with no field");
  init_end_a: assert property ($rose(initialized) |=> done)
    else $error("init end out of step");
  cap_sum_a: assert property (!ini_q && !$past(ini_q) &&
    !$past(ini_q, 2) && !$past(sys_rst) && !$past(sys_rst, 2) &&
    $past(initialized) && $past(initialized, 2) &&
    $past(src_cpu) == $past(src_cpu, 2) &&
    $past(dst_cpu) == $past(dst_cpu, 2) |-> sum == $past(sum))
    else $error("capacity sum changed");
  cover property (done && refused);
  cover property (recv_data_valid ##1 recv_data_valid);
  cover property ($rose(initialized));
endmodule : mlb_buffer_chk
bind mlb_buffer mlb_buffer_chk u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .init_req(init_req),
  .send_req(send_req), .recv_req(recv_req), .src_cpu(src_cpu),
  .dst_cpu(dst_cpu), .send_len(send_len), .send_data_take(send_data_take),
  .recv_data_valid(recv_data_valid), .recv_len(recv_len), .tx_cap(tx_cap),
  .rx_cap(rx_cap), .busy(busy), .done(done), .refused(refused),
  .initialized(initialized)
);

// [dv/mlb_cpu_model.sv]
// Sending CPU model that feeds record words
`timescale 1ns/100ps
module mlb_cpu_model
  import mlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic send_data_take,
  input wire logic [MLB_DATA_W-1:0] word_base,
  output logic [MLB_DATA_W-1:0] send_data
);
  logic [MLB_DATA_W-1:0] idx_q = 16'h0000;
  wire [MLB_DATA_W-1:0] word_now = word_base + idx_q;
  // Word n stands while take pulse n is high
  assign send_data = (send_data_take === 1'b1) ? word_now : ~word_now;
  always @(posedge ref_clk) begin
    if (send_data_take === 1'b1) begin
      idx_q <= idx_q + 16'h0001;
    end else if (busy !== 1'b1) begin
      idx_q <= 16'h0000;
    end
  end
endmodule : mlb_cpu_model

// [dv/tb.sv]
// Self-checking bench for the link buffer
`timescale 1ns/100ps
module tb;
  import mlb_pkg::*;
  typedef struct packed {
    logic sn; logic [1:0] s; logic [1:0] d; logic [5:0] ln;
    logic [15:0] b; logic rf; logic [5:0] tx; logic [5:0] rx;
  } mlb_row_s;
  logic ref_clk = 0, sys_rst = 1, init_req = 0, init_load = 0;
  logic send_req = 0, recv_req = 0;
  logic [3:0] init_link = 4'h0;
  logic [5:0] init_count = 6'h00, send_len = 6'h00;
  logic [1:0] src_cpu = 2'h0, dst_cpu = 2'h0;
  logic [15:0] send_data, recv_data, word_base = 16'h0000;
  logic send_data_take, recv_data_valid, busy, done, refused;
  logic init_error, initialized, got_rf;
  logic [5:0] recv_len, tx_cap, rx_cap;
  logic [5:0] res [16];
  logic [15:0] got_w [40];
  int nw, error_cnt = 0, n_compared = 0;
  mlb_row_s rows [10];
  always #10 ref_clk = ~ref_clk;
  mlb_buffer u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .init_req(init_req),
    .init_link(init_link), .init_count(init_count), .init_load(init_load),
    .send_req(send_req), .recv_req(recv_req), .src_cpu(src_cpu),
    .dst_cpu(dst_cpu), .send_len(send_len), .send_data(send_data),
    .send_data_take(send_data_take), .recv_data(recv_data),
    .recv_data_valid(recv_data_valid), .recv_len(recv_len),
    .tx_cap(tx_cap), .rx_cap(rx_cap), .busy(busy), .done(done),
    .refused(refused), .init_error(init_error), .initialized(initialized)
  );
  mlb_cpu_model u_cpu (
    .ref_clk(ref_clk), .busy(busy), .send_data_take(send_data_take),
    .word_base(word_base), .send_data(send_data)
  );
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_done();
    int k;
    nw = 0;
    k = 0;
    while (done !== 1'b1 && k < 90) begin
      @(negedge ref_clk);
      if (recv_data_valid === 1'b1 && nw < 40) begin
        got_w[nw] = recv_data;
        nw++;
      end
      k++;
    end
    got_rf = refused;
    chk("done", 32'(done), 32'h1);
  endtask : wait_done
  task automatic op(input mlb_row_s r);
    int i;
    @(posedge ref_clk);
    src_cpu <= r.s;
    dst_cpu <= r.d;
    send_len <= r.ln;
    word_base <= r.b;
    repeat (2) @(posedge ref_clk);
    send_req <= r.sn;
    recv_req <= !r.sn;
    @(posedge ref_clk);
    send_req <= 0;
    recv_req <= 0;
    wait_done();
    chk("refused", 32'(got_rf), 32'(r.rf));
    if (!r.sn && !r.rf) begin
      chk("words", nw, 32'(r.ln));
      chk("recv_len", 32'(recv_len), 32'(r.ln));
      for (i = 0; i < nw; i++) chk("word", got_w[i], r.b + i);
    end
    repeat (2) @(negedge ref_clk);
    chk("tx_cap", 32'(tx_cap), 32'(r.tx));
    chk("rx_cap", 32'(rx_cap), 32'(r.rx));
  endtask : op
  task automatic do_init();
    int k;
    @(posedge ref_clk);
    init_req <= 1;
    @(posedge ref_clk);
    init_req <= 0;
    repeat (3) @(posedge ref_clk);
    for (k = 0; k < 16; k++) begin
      init_link <= 4'(k);
      init_count <= res[k];
      init_load <= 1;
      @(posedge ref_clk);
    end
    init_load <= 0;
    wait_done();
    chk("initialized", 32'(initialized), 32'h1);
  endtask : do_init
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    // Rows: send, src, dst, len, base, refused, tx_cap, rx_cap
    rows[0] = '{1, 0, 1, 1, 16'h1000, 0, 1, 1};
    rows[1] = '{1, 0, 1, 32, 16'h2000, 0, 0, 2};
    rows[2] = '{1, 0, 1, 2, 16'h0000, 1, 0, 2};
    rows[3] = '{1, 1, 2, 3, 16'h3000, 0, 0, 1};
    rows[4] = '{0, 0, 1, 1, 16'h1000, 0, 1, 1};
    rows[5] = '{1, 0, 1, 0, 16'h0000, 1, 1, 1};
    rows[6] = '{0, 0, 1, 32, 16'h2000, 0, 2, 0};
    rows[7] = '{0, 0, 1, 0, 16'h0000, 1, 2, 0};
    rows[8] = '{0, 1, 2, 3, 16'h3000, 0, 1, 0};
    rows[9] = '{1, 0, 1, 33, 16'h0000, 1, 2, 0};
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    @(negedge ref_clk);
    chk("rx_cap", 32'(rx_cap), 32'h0);
    op('{1, 0, 1, 1, 16'h0000, 1, 0, 0});
    $display("reset test done");
    foreach (res[k]) res[k] = 6'h00;
    res[1] = 6'h02;
    res[6] = 6'h01;
    do_init();
    foreach (rows[i]) op(rows[i]);
    $display("table test done");
    op('{1, 0, 1, 4, 16'h4000, 0, 1, 1});
    do_init();
    repeat (2) @(negedge ref_clk);
    chk("rx_cap", 32'(rx_cap), 32'h0);
    op('{0, 0, 1, 0, 16'h0000, 1, 2, 0});
    $display("discard test done");
    foreach (res[k]) res[k] = 6'h03;
    res[0] = 6'h04;
    do_init();
    chk("init_error", 32'(init_error), 32'h1);
    op('{1, 3, 3, 1, 16'h0000, 1, 0, 0});
    $display("pool test done");
    op('{1, 0, 0, 2, 16'h5000, 0, 3, 1});
    @(posedge ref_clk);
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    @(negedge ref_clk);
    chk("initialized", 32'(initialized), 32'h1);
    op('{0, 0, 0, 2, 16'h5000, 0, 4, 0});
    op('{0, 0, 0, 0, 16'h0000, 1, 4, 0});
    $display("second reset test done");
    wrap_up();
  end
endmodule : tb

// [rtl/mlb_buffer.sv]
// Link buffer manager: field pool, per-link queues and capacities
//
// Notes on behaviour
// - Each link delivers fields in deposit order.
// - Links are transmitter/receiver pairs, fully independent.
// - Pool holds 48 fields of 32 words.
// - Initialization reserves a field count per link.
// - One field holds one record, 1-32 words.
// - Send fills a free field; receive releases it.
// - Transmitting capacity equals free reserved fields.
// - Transmit plus receive capacity equals reservation.
// - Memory has no reset; contents survive restart.
// - Zero transmitting capacity blocks the sender.
// - Nonzero receiving capacity means data waiting.
// - Initialization discards all buffered records.
`timescale 1ns/100ps
module mlb_buffer
  import mlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic init_req,
  input wire logic [MLB_LINK_W-1:0] init_link,
  input wire logic [MLB_CNT_W-1:0] init_count,
  input wire logic init_load,
  input wire logic send_req,
  input wire logic recv_req,
  input wire logic [MLB_CPU_W-1:0] src_cpu,
  input wire logic [MLB_CPU_W-1:0] dst_cpu,
  input wire logic [MLB_LEN_W-1:0] send_len,
  input wire logic [MLB_DATA_W-1:0] send_data,
  output logic send_data_take,
  output logic [MLB_DATA_W-1:0] recv_data,
  output logic recv_data_valid,
  output logic [MLB_LEN_W-1:0] recv_len,
  output logic [MLB_CNT_W-1:0] tx_cap,
  output logic [MLB_CNT_W-1:0] rx_cap,
  output logic busy,
  output logic done,
  output logic refused,
  output logic init_error,
  output logic initialized
);
  // Per-link bookkeeping; the queue order lives in a linked list of fields
  logic [MLB_CNT_W-1:0] resv_q [MLB_LINKS];
  logic [MLB_CNT_W-1:0] fill_q [MLB_LINKS];
  logic [MLB_FIELD_W-1:0] head_q [MLB_LINKS];
  logic [MLB_FIELD_W-1:0] tail_q [MLB_LINKS];
  logic [MLB_FIELD_W-1:0] next_q [MLB_FIELDS];
  logic [MLB_LEN_W-1:0] flen_q [MLB_FIELDS];
  logic [MLB_FIELD_W-1:0] free_head_q;
  logic [MLB_FIELD_W:0] free_cnt_q;
  logic [MLB_FIELD_W:0] resv_total_q;

  mlb_state_e state_q;
  logic [MLB_LINK_W-1:0] link_q;
  logic [MLB_FIELD_W-1:0] field_q;
  logic [MLB_LEN_W-1:0] len_q;
  logic [MLB_WORD_W-1:0] word_q;
  logic [MLB_FIELD_W-1:0] init_idx_q;
  logic send_take_q;
  logic rd_pend_q;
  logic [MLB_DATA_W-1:0] recv_data_q;
  logic recv_valid_q;
  logic [MLB_LEN_W-1:0] recv_len_q;
  logic [MLB_CNT_W-1:0] tx_cap_q;
  logic [MLB_CNT_W-1:0] rx_cap_q;
  logic busy_q;
  logic done_q;
  logic refused_q;
  logic init_err_q;
  // Power-on value only; a restart keeps it
  logic inited_q = 1'b0;
  logic [MLB_DATA_W-1:0] mem_rd;

  function automatic logic [MLB_LINK_W-1:0] link_of(
    input logic [MLB_CPU_W-1:0] s,
    input logic [MLB_CPU_W-1:0] d
  );
    link_of = {s, d};
  endfunction : link_of

  function automatic logic [MLB_MEM_AW-1:0] addr_of(
    input logic [MLB_FIELD_W-1:0] f,
    input logic [MLB_WORD_W-1:0] w
  );
    addr_of = {f, w};
  endfunction : addr_of

  wire [MLB_LINK_W-1:0] req_link = link_of(src_cpu, dst_cpu);
  wire [MLB_CNT_W-1:0] req_tx = resv_q[req_link] - fill_q[req_link];
  wire [MLB_CNT_W-1:0] req_rx = fill_q[req_link];
  wire can_send = inited_q && req_tx != MLB_CNT_ZERO && send_len != 6'h00
    && send_len <= MLB_LEN_MAX && free_cnt_q != 7'h00;
  wire can_recv = inited_q && req_rx != MLB_CNT_ZERO;
  wire [MLB_FIELD_W:0] resv_sum = resv_total_q + {1'b0, init_count};
  wire init_fits = resv_sum <= 7'(MLB_FIELDS);
  wire last_word = {1'b0, word_q} == len_q - 6'h01;
  wire mem_we = state_q == MLB_SEND;
  wire [MLB_MEM_AW-1:0] mem_wa = addr_of(field_q, word_q);
  wire [MLB_MEM_AW-1:0] mem_ra = addr_of(field_q, word_q);
  wire op_idle = state_q == MLB_IDLE;
  wire init_slot = state_q == MLB_INIT && init_load
    && init_idx_q != MLB_FIELD_ZERO;
  wire init_drop = init_slot && !init_fits;

  // No reset on the storage array so contents survive restarts
  mlb_mem u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(send_data),
    .rd_addr(mem_ra),
    .rd_data_q(mem_rd)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= MLB_IDLE;
      link_q <= MLB_LINK_ZERO;
      field_q <= MLB_FIELD_ZERO;
      len_q <= 6'h00;
      word_q <= MLB_WORD_ZERO;
      init_idx_q <= MLB_FIELD_ZERO;
      send_take_q <= 1'b0;
      recv_len_q <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      send_take_q <= 1'b0;
      unique case (state_q)
        MLB_IDLE: begin
          if (init_req) begin
            state_q <= MLB_INIT;
            init_idx_q <= MLB_FIELD_ZERO;
            busy_q <= 1'b1;
          end else if (send_req) begin
            if (can_send) begin
              state_q <= MLB_SEND;
              link_q <= req_link;
              field_q <= free_head_q;
              len_q <= send_len;
              word_q <= MLB_WORD_ZERO;
              send_take_q <= 1'b1;
              busy_q <= 1'b1;
            end else begin
              refused_q <= 1'b1;
              done_q <= 1'b1;
            end
          end else if (recv_req) begin
            if (can_recv) begin
              state_q <= MLB_RECV;
              link_q <= req_link;
              field_q <= head_q[req_link];
              len_q <= flen_q[head_q[req_link]];
              recv_len_q <= flen_q[head_q[req_link]];
              word_q <= MLB_WORD_ZERO;
              busy_q <= 1'b1;
            end else begin
              refused_q <= 1'b1;
              done_q <= 1'b1;
            end
          end
        end
        MLB_INIT: begin
          if (init_idx_q == MLB_FIELD_LAST) begin
            state_q <= MLB_DONE;
          end
          init_idx_q <= init_idx_q + 6'h01;
        end
        MLB_SEND: begin
          if (last_word) begin
            state_q <= MLB_DONE;
          end else begin
            send_take_q <= 1'b1;
          end
          word_q <= word_q + 5'h01;
        end
        MLB_RECV: begin
          if (last_word) begin
            state_q <= MLB_RLAT;
          end
          word_q <= word_q + 5'h01;
        end
        MLB_RLAT: begin
          state_q <= MLB_DONE;
        end
        MLB_DONE: begin
          state_q <= MLB_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        default: begin
          state_q <= MLB_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Read path: one cycle in the memory, one into the output register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_pend_q <= 1'b0;
      recv_valid_q <= 1'b0;
      recv_data_q <= 16'h0000;
    end else begin
      rd_pend_q <= state_q == MLB_RECV;
      recv_valid_q <= rd_pend_q;
      if (rd_pend_q) begin
        recv_data_q <= mem_rd;
      end
    end
  end

  // Overflowing reservation flag, cleared when a new sweep is taken
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      init_err_q <= 1'b0;
    end else if (op_idle && init_req) begin
      init_err_q <= 1'b0;
    end else if (init_drop) begin
      init_err_q <= 1'b1;
    end
  end

  // Queue bookkeeping: free list, link lists, counts
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      inited_q <= inited_q; // Kept through restart
    end else if (state_q == MLB_INIT) begin
      next_q[init_idx_q] <= init_idx_q + 6'h01;
      flen_q[init_idx_q] <= 6'h00;
      if (init_idx_q == MLB_FIELD_ZERO) begin
        free_head_q <= MLB_FIELD_ZERO;
        free_cnt_q <= 7'(MLB_FIELDS);
        resv_total_q <= 7'h00;
        inited_q <= 1'b0;
        for (int i = 0; i < MLB_LINKS; i++) begin
          resv_q[i] <= MLB_CNT_ZERO;
          fill_q[i] <= MLB_CNT_ZERO;
        end
      end
      if (init_idx_q == MLB_FIELD_LAST) begin
        inited_q <= 1'b1;
      end
      if (init_slot && init_fits) begin
        resv_q[init_link] <= init_count;
        resv_total_q <= resv_sum;
      end
    end else if (op_idle && send_req && !init_req && can_send) begin
      free_head_q <= next_q[free_head_q];
      free_cnt_q <= free_cnt_q - 7'h01;
      flen_q[free_head_q] <= send_len;
      if (fill_q[req_link] == MLB_CNT_ZERO) begin
        head_q[req_link] <= free_head_q;
      end else begin
        next_q[tail_q[req_link]] <= free_head_q;
      end
      tail_q[req_link] <= free_head_q;
      fill_q[req_link] <= fill_q[req_link] + MLB_CNT_ONE;
    end else if (op_idle && recv_req && !send_req && !init_req
        && can_recv) begin
      head_q[req_link] <= next_q[head_q[req_link]];
      next_q[head_q[req_link]] <= free_head_q;
      free_head_q <= head_q[req_link];
      free_cnt_q <= free_cnt_q + 7'h01;
      fill_q[req_link] <= fill_q[req_link] - MLB_CNT_ONE;
    end
  end

  // Capacities reported for the addressed link
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_cap_q <= MLB_CNT_ZERO;
      rx_cap_q <= MLB_CNT_ZERO;
    end else begin
      tx_cap_q <= inited_q ? req_tx : MLB_CNT_ZERO;
      rx_cap_q <= inited_q ? req_rx : MLB_CNT_ZERO;
    end
  end

  assign send_data_take = send_take_q;
  assign recv_data = recv_data_q;
  assign recv_data_valid = recv_valid_q;
  assign recv_len = recv_len_q;
  assign tx_cap = tx_cap_q;
  assign rx_cap = rx_cap_q;
  assign busy = busy_q;
  assign done = done_q;
  assign refused = refused_q;
  assign init_error = init_err_q;
  assign initialized = inited_q;
endmodule : mlb_buffer

// [rtl/mlb_mem.sv]
// Field storage memory with registered read data
`timescale 1ns/100ps
module mlb_mem
  import mlb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [MLB_MEM_AW-1:0] wr_addr,
  input wire logic [MLB_DATA_W-1:0] wr_data,
  input wire logic [MLB_MEM_AW-1:0] rd_addr,
  output logic [MLB_DATA_W-1:0] rd_data_q
);
  logic [MLB_DATA_W-1:0] mem [MLB_FIELDS*MLB_WORDS];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_q <= mem[rd_addr];
  end
endmodule : mlb_mem

// [rtl/mlb_pkg.sv]
// Package of constants and types for the multiprocessor link buffer
package mlb_pkg;
  localparam int MLB_CPUS = 4;
  localparam int MLB_CPU_W = 2;
  localparam int MLB_LINKS = MLB_CPUS * MLB_CPUS;
  localparam int MLB_LINK_W = 4;
  localparam int MLB_FIELDS = 48;
  localparam int MLB_FIELD_W = 6;
  localparam int MLB_WORDS = 32;
  localparam int MLB_WORD_W = 5;
  localparam int MLB_LEN_W = 6;
  localparam int MLB_DATA_W = 16;
  localparam int MLB_CNT_W = 6;
  localparam int MLB_MEM_AW = MLB_FIELD_W + MLB_WORD_W;
  localparam logic [MLB_CNT_W-1:0] MLB_CNT_ZERO = 6'h00;
  localparam logic [MLB_CNT_W-1:0] MLB_CNT_ONE = 6'h01;
  localparam logic [MLB_FIELD_W-1:0] MLB_FIELD_ZERO = 6'h00;
  localparam logic [MLB_FIELD_W-1:0] MLB_FIELD_LAST = 6'h2f;
  localparam logic [MLB_WORD_W-1:0] MLB_WORD_ZERO = 5'h00;
  localparam logic [MLB_LINK_W-1:0] MLB_LINK_ZERO = 4'h0;
  localparam logic [MLB_LINK_W-1:0] MLB_LINK_LAST = 4'hf;
  localparam logic [MLB_LEN_W-1:0] MLB_LEN_MAX = 6'h20;

  typedef enum logic [5:0] {
    MLB_IDLE = 6'b000001,
    MLB_INIT = 6'b000010,
    MLB_SEND = 6'b000100,
    MLB_RECV = 6'b001000,
    MLB_RLAT = 6'b010000,
    MLB_DONE = 6'b100000
  } mlb_state_e;
endpackage : mlb_pkg
